//--- stage_cmd_pkg.sv
// Package: timing, bundles and states for the stage command host controller
package stage_cmd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int T_SETTLE_NS     = 1000;    // Relay pick / verify settle time
    localparam int T_FRESET_NS     = 2000;    // Forced reset pulse width
    localparam int T_READ_NS       = 5000;    // Read command width
    localparam int T_AUTO_RESET_NS = 10000;   // Wait for the unit's automatic reset

    // Least times round up to whole cycles
    localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRESET_CYC = (T_FRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC   = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AUTO_CYC   = (T_AUTO_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int TIMER_W    = 12;
    localparam int CODE_W     = 8;
    localparam int MAX_PRECHK = 3;            // Forced resets tried before giving up
    localparam int RETRY_W    = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Line bundle toward the units (shared lines)
    typedef struct packed {
        logic [CODE_W-1:0] code;               // Command bits 8..1
        logic              read;               // Read command
        logic              force_reset;        // Forced reset
    } line_drive_t;

    // Outcome of one command cycle
    typedef struct packed {
        logic fail;                            // Units never showed reset
        logic used_complement;                 // Complement form was sent
        logic verify_match;                    // First verification matched
    } cmd_result_t;

    ////////////////////////////////////////////////////////////////////////////
    // Controller states
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_PRECHECK  = 4'h1,
        ST_FRESET    = 4'h2,
        ST_RECOVER   = 4'h3,
        ST_LOAD      = 4'h4,
        ST_LOAD_COMP = 4'h5,
        ST_READ      = 4'h6,
        ST_AUTO_WAIT = 4'h7,
        ST_DONE      = 4'h8
    } host_state_t;

endpackage

//--- cycle_timer.sv
// Down-counting interval timer
`timescale 1ns/1ps

module cycle_timer #(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    // Control
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_count,
    // Status
    output logic                  o_done
);

    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    // Load count minus one so an interval of N lasts N cycles
    assign cnt_nxt = i_load ? (i_count - WIDTH'(1))
                   : (cnt_r != '0) ? (cnt_r - WIDTH'(1)) : cnt_r;
    assign o_done  = (cnt_r == '0);

    // Counter register
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

endmodule

//--- stage_cmd_host.sv
// Host controller that drives stage command decoder units over their lines
`timescale 1ns/1ps

// Operation
// [R1] Each unit has its own select line; command lines are shared.
// [R2] Never assert more than two unit selects at once.
// [R3] Unit latches selected state on select until reset.
// [R4] Unit stores the eight command bits while selected.
// [R5] Command bits stay valid for the whole time select is driven.
// [R6] Unit returns the complement of stored bits on verify lines.
// [R7] Unit ignores read unless already selected.
// [R8] Read enables decoding of stored command to one channel.
// [R9] Read on verify match; otherwise forced reset, reselect, complement, read.
// [R10] Forced reset clears selected state and input register.
// [R11] After a complement command, read without checking verification.
// [R12] Unit resets itself automatically at power-up.
// [R13] Unit resets itself automatically after read is removed.
// [R14] Bits 1-3 pick column, 4-6 row, 7-8 feed gate generator.
// [R15] Bit 8 marks true form (low) or complement form (high).
// [R16] Gate generator forms six read-qualified terms from bits 7, 8.
// [R17] A command and its complement activate the same channel.
// [R18] Column from bits 8,3,2,1; row from bits 8,7,6,5,4.
// [R19] Before loading, verify lines must be low; else forced reset, recheck.
// [R20] Row and column address a seven by sixteen output matrix; the unit model decodes sixteen rows by eight columns.
// [R21] Outputs are off when read is low or unit not selected.
// [R22] Unit samples its inputs on a local clock with counted reset pulse.
module stage_cmd_host #(
    parameter int N_UNITS = 4
) (
    // Clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_srst,
    // Command request
    input  wire logic                          i_cmd_valid,
    input  wire logic [$clog2(N_UNITS)-1:0]    i_cmd_unit,
    input  wire logic [stage_cmd_pkg::CODE_W-1:0] i_cmd_code,
    output logic                               o_cmd_ready,
    // Command completion
    output logic                               o_done,
    output stage_cmd_pkg::cmd_result_t         o_result,
    // Unit lines
    output logic [N_UNITS-1:0]                 o_sel,
    output stage_cmd_pkg::line_drive_t         o_lines,
    input  wire logic [stage_cmd_pkg::CODE_W-1:0] i_verify
);

    localparam int TW = stage_cmd_pkg::TIMER_W;
    localparam int CW = stage_cmd_pkg::CODE_W;
    localparam int UW = $clog2(N_UNITS);

    ////////////////////////////////////////////////////////////////////////////
    // State and holding registers
    stage_cmd_pkg::host_state_t state_r;
    stage_cmd_pkg::host_state_t state_nxt;
    logic [UW-1:0]                     unit_r;
    logic [UW-1:0]                     unit_nxt;
    logic [CW-1:0]                     code_r;
    logic [CW-1:0]                     code_nxt;
    logic                              comp_r;        // Complement phase
    logic                              comp_nxt;
    logic [stage_cmd_pkg::RETRY_W-1:0] retry_r;
    logic [stage_cmd_pkg::RETRY_W-1:0] retry_nxt;
    stage_cmd_pkg::cmd_result_t        result_nxt;
    logic [N_UNITS-1:0]                sel_nxt;
    stage_cmd_pkg::line_drive_t        lines_nxt;
    logic                              done_nxt;

    // Timer wiring
    logic          t_load;
    logic [TW-1:0] t_count;
    logic          t_done;

    ////////////////////////////////////////////////////////////////////////////
    // Decodes of state and verify lines
    wire accept       = (state_r == stage_cmd_pkg::ST_IDLE) && i_cmd_valid;
    wire verify_clear = (i_verify == '0);
    wire verify_match = (i_verify == ~code_r);
    wire retry_out    = (retry_r == stage_cmd_pkg::RETRY_W'(stage_cmd_pkg::MAX_PRECHK));
    wire drive_sel    = (state_nxt == stage_cmd_pkg::ST_LOAD)
                     || (state_nxt == stage_cmd_pkg::ST_LOAD_COMP)
                     || (state_nxt == stage_cmd_pkg::ST_READ);

    assign o_cmd_ready = (state_r == stage_cmd_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        state_nxt  = state_r;
        unit_nxt   = unit_r;
        code_nxt   = code_r;
        comp_nxt   = comp_r;
        retry_nxt  = retry_r;
        result_nxt = o_result;
        done_nxt   = 1'b0;
        case (state_r)
            stage_cmd_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    unit_nxt   = i_cmd_unit;
                    code_nxt   = i_cmd_code;
                    comp_nxt   = 1'b0;
                    retry_nxt  = '0;
                    result_nxt = '0;
                    state_nxt  = stage_cmd_pkg::ST_PRECHECK;
                end
            end
            stage_cmd_pkg::ST_PRECHECK:
            begin
                if (t_done)
                begin
                    if (verify_clear)
                        state_nxt = stage_cmd_pkg::ST_LOAD;
                    else if (retry_out)
                    begin
                        result_nxt.fail = 1'b1;
                        state_nxt       = stage_cmd_pkg::ST_DONE;
                    end
                    else
                    begin
                        retry_nxt = retry_r + stage_cmd_pkg::RETRY_W'(1);
                        state_nxt = stage_cmd_pkg::ST_FRESET;            // R19
                    end
                end
            end
            stage_cmd_pkg::ST_FRESET:
            begin
                if (t_done)
                    state_nxt = stage_cmd_pkg::ST_RECOVER;
            end
            stage_cmd_pkg::ST_RECOVER:
            begin
                if (t_done)
                    state_nxt = comp_r ? stage_cmd_pkg::ST_LOAD_COMP     // R9
                                       : stage_cmd_pkg::ST_PRECHECK;     // R19
            end
            stage_cmd_pkg::ST_LOAD:
            begin
                if (t_done)
                begin
                    if (verify_match)
                    begin
                        result_nxt.verify_match = 1'b1;
                        state_nxt               = stage_cmd_pkg::ST_READ; // R9
                    end
                    else
                    begin
                        comp_nxt                   = 1'b1;
                        result_nxt.used_complement = 1'b1;
                        state_nxt                  = stage_cmd_pkg::ST_FRESET; // R9
                    end
                end
            end
            stage_cmd_pkg::ST_LOAD_COMP:
            begin
                if (t_done)
                    state_nxt = stage_cmd_pkg::ST_READ;                  // R11
            end
            stage_cmd_pkg::ST_READ:
            begin
                if (t_done)
                    state_nxt = stage_cmd_pkg::ST_AUTO_WAIT;
            end
            stage_cmd_pkg::ST_AUTO_WAIT:
            begin
                if (t_done)
                    state_nxt = stage_cmd_pkg::ST_DONE;
            end
            stage_cmd_pkg::ST_DONE:
            begin
                done_nxt  = 1'b1;
                state_nxt = stage_cmd_pkg::ST_IDLE;
            end
            default:
                state_nxt = stage_cmd_pkg::ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interval per state, loaded on every state change
    assign t_load  = (state_nxt != state_r);
    assign t_count =
        (state_nxt == stage_cmd_pkg::ST_FRESET)    ? TW'(stage_cmd_pkg::FRESET_CYC) :
        (state_nxt == stage_cmd_pkg::ST_READ)      ? TW'(stage_cmd_pkg::READ_CYC)   :
        (state_nxt == stage_cmd_pkg::ST_AUTO_WAIT) ? TW'(stage_cmd_pkg::AUTO_CYC)   :
                                                     TW'(stage_cmd_pkg::SETTLE_CYC);

    cycle_timer #(
        .WIDTH   (TW)
    ) u_timer (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_load  (t_load),
        .i_count (t_count),
        .o_done  (t_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Line values for the coming state
    assign sel_nxt               = drive_sel ? (N_UNITS'(1) << unit_nxt) : '0;   // R1 R2
    assign lines_nxt.code        = drive_sel ? (comp_nxt ? ~code_nxt : code_nxt) : '0; // R5
    assign lines_nxt.read        = (state_nxt == stage_cmd_pkg::ST_READ);   // R9
    assign lines_nxt.force_reset = (state_nxt == stage_cmd_pkg::ST_FRESET); // R9 R19

    // Registers
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_r  <= stage_cmd_pkg::ST_IDLE;
            unit_r   <= '0;
            code_r   <= '0;
            comp_r   <= 1'b0;
            retry_r  <= '0;
            o_result <= '0;
            o_done   <= 1'b0;
            o_sel    <= '0;
            o_lines  <= '0;
        end
        else
        begin
            state_r  <= state_nxt;
            unit_r   <= unit_nxt;
            code_r   <= code_nxt;
            comp_r   <= comp_nxt;
            retry_r  <= retry_nxt;
            o_result <= result_nxt;
            o_done   <= done_nxt;
            o_sel    <= sel_nxt;
            o_lines  <= lines_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_verify_good;
        (state_r == stage_cmd_pkg::ST_LOAD) && t_done && (i_verify == ~o_lines.code);
    endsequence

    sequence s_verify_bad;
        (state_r == stage_cmd_pkg::ST_LOAD) && t_done && (i_verify != ~o_lines.code);
    endsequence

    a_sel_at_most_one: assert property (@(posedge i_clk) disable iff (i_srst) // R1
        $countones(o_sel) <= 1)
        else $error("more than one unit select driven");

    a_sel_limit_two: assert property (@(posedge i_clk) disable iff (i_srst) // R2
        $countones(o_sel) <= 2)
        else $error("select limit exceeded");

    a_code_held_sel: assert property (@(posedge i_clk) disable iff (i_srst) // R5
        (o_sel != '0) && ($past(o_sel) == o_sel) |-> $stable(o_lines.code))
        else $error("command bits changed while select driven");

    a_match_then_read: assert property (@(posedge i_clk) disable iff (i_srst) // R9
        s_verify_good |=> o_lines.read && (o_sel != '0) && $stable(o_lines.code))
        else $error("read not issued after matching verification");

    a_mismatch_reset: assert property (@(posedge i_clk) disable iff (i_srst) // R9
        s_verify_bad |=> o_lines.force_reset && (o_sel == '0) && !o_lines.read)
        else $error("forced reset not issued after mismatch");

    a_comp_blind_read: assert property (@(posedge i_clk) disable iff (i_srst) // R11
        (state_r == stage_cmd_pkg::ST_LOAD_COMP) && t_done
            |=> o_lines.read && (o_lines.code == ~code_r))
        else $error("complement command not followed by read");

    a_precheck_reset: assert property (@(posedge i_clk) disable iff (i_srst) // R19
        (state_r == stage_cmd_pkg::ST_PRECHECK) && t_done && !verify_clear && !retry_out
            |=> o_lines.force_reset [*2])
        else $error("verify lines high but no forced reset");

    a_load_needs_clear: assert property (@(posedge i_clk) disable iff (i_srst) // R19
        $rose(o_sel != '0) && !comp_r |-> $past(i_verify) == '0)
        else $error("command loaded without clear verify lines");

endmodule

//--- stage_unit_model.sv
// Behavioural model of the decoder units on the host's far side
`timescale 1ns/1ps

module stage_unit_model #(
    parameter int N_UNITS = 4,
    parameter int PULSE   = 50
) (
    // Clock and power
    input  wire logic                       i_clk,
    input  wire logic                       i_srst,
    // Host lines
    input  wire logic [N_UNITS-1:0]         i_sel,
    input  wire stage_cmd_pkg::line_drive_t i_lines,
    output logic [7:0]                      o_verify,
    // Fault injection
    input  wire logic [7:0]                 i_flip,
    input  wire logic                       i_preset,
    // Activated channel
    output logic [N_UNITS-1:0]              o_hit,
    output logic [3:0]                      o_row,
    output logic [2:0]                      o_col
);
    logic [N_UNITS-1:0] sel_r;
    logic [7:0]         reg_r [N_UNITS];
    logic [7:0]         flip_r;
    logic [7:0]         pulse_r;
    logic               read_q_r;
    logic [7:0]         dec;

    // Gate generator and row/column decode of stored bits
    function automatic logic [7:0] decode(input logic [7:0] b, input logic rd);
        logic g1, g1n, g2, g3, g4, g5;
        g1  = b[7] & rd;
        g1n = ~b[7] & rd;
        g2  = g1 & b[6];
        g3  = g1 & ~b[6];
        g4  = g1n & ~b[6];
        g5  = g1n & b[6];
        decode = {g2 | g3 | g4 | g5, g5 | g3, g1 ? ~b[5:0] : b[5:0]};
    endfunction

    // Verify lines and activated channel
    always_comb
    begin
        o_verify = 8'h00;
        o_hit = '0;
        o_row = 4'h0;
        o_col = 3'h0;
        for (int u = 0; u < N_UNITS; u++)
        begin
            dec = decode(reg_r[u], i_lines.read & sel_r[u]);
            if (sel_r[u])
                o_verify = o_verify | ~reg_r[u];
            if (dec[7])
            begin
                o_hit[u] = 1'b1;
                o_row = dec[6:3];
                o_col = dec[2:0];
            end
        end
    end

    // Latches, automatic reset pulse and one-shot capture fault
    always_ff @(posedge i_clk)
    begin
        read_q_r <= i_lines.read;
        // Cleared at power-up too, so a clean capture never sees an unknown fault
        flip_r <= (i_srst | i_lines.force_reset) ? 8'h00
                : ((i_flip != 8'h00) ? i_flip : flip_r);
        if (i_srst | (read_q_r & ~i_lines.read))
            pulse_r <= 8'(PULSE);
        else if (pulse_r != 8'h00)
            pulse_r <= pulse_r - 8'h01;
        for (int u = 0; u < N_UNITS; u++)
        begin
            if ((pulse_r != 8'h00) | i_lines.force_reset)
            begin
                sel_r[u] <= 1'b0;
                reg_r[u] <= 8'h00;
            end
            else
            begin
                if (i_sel[u] | (i_preset & (u == 0)))
                    sel_r[u] <= 1'b1;
                if (sel_r[u] & i_sel[u])
                    reg_r[u] <= i_lines.code ^ flip_r;
            end
        end
    end
endmodule

//--- stage_cmd_host_bench.sv
// Self-checking bench for the stage command host controller
`timescale 1ns/1ps

module stage_cmd_host_bench;
    logic                       i_clk = 1'b0;
    logic                       i_srst = 1'b1;
    logic                       i_cmd_valid = 1'b0;
    logic [1:0]                 i_cmd_unit = 2'h0;
    logic [7:0]                 i_cmd_code = 8'h00;
    logic                       o_cmd_ready;
    logic                       o_done;
    stage_cmd_pkg::cmd_result_t o_result;
    logic [3:0]                 o_sel;
    stage_cmd_pkg::line_drive_t o_lines;
    logic [7:0]                 i_verify;
    logic [7:0]                 flip = 8'h00;
    logic                       preset = 1'b0;
    logic [3:0]                 hit;
    logic [3:0]                 row;
    logic [2:0]                 col;
    logic [3:0]                 hit_seen;
    logic [6:0]                 chan_seen;
    logic [3:0]                 sel_q = 4'h0;
    logic [7:0]                 code_q = 8'h00;
    logic                       fr_q = 1'b0;
    logic [31:0]                lfsr = 32'h17B0;
    int                         fr_count;
    int                         mismatches = 0;
    int                         num_checks = 0;

    stage_cmd_host #(.N_UNITS(4)) DUT (.i_clk(i_clk), .i_srst(i_srst),
        .i_cmd_valid(i_cmd_valid), .i_cmd_unit(i_cmd_unit), .i_cmd_code(i_cmd_code),
        .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_result(o_result),
        .o_sel(o_sel), .o_lines(o_lines), .i_verify(i_verify));

    stage_unit_model #(.N_UNITS(4), .PULSE(50)) units (.i_clk(i_clk), .i_srst(i_srst),
        .i_sel(o_sel), .i_lines(o_lines), .o_verify(i_verify), .i_flip(flip),
        .i_preset(preset), .o_hit(hit), .o_row(row), .o_col(col));

    // Clock
    always #5 i_clk = ~i_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Channel that a true or complement command must reach
    function automatic logic [6:0] exp_chan(input logic [7:0] c);
        exp_chan = c[7] ? ~c[6:0] : c[6:0];
    endfunction

    // Line monitor: held code, select count, channel and forced resets
    always @(posedge i_clk)
    begin
        if (o_sel != 4'h0 && o_sel === sel_q)
            check(o_lines.code, code_q, "code moved under select");
        if (o_sel != 4'h0)
            check($countones(o_sel) <= 2, 1'b1, "too many selects");
        if (o_lines.read !== 1'b1)
            check(hit, 4'h0, "channel active without read");
        if (o_lines.force_reset === 1'b1 && fr_q === 1'b0)
            fr_count++;
        if (o_lines.read === 1'b1 && hit != 4'h0)
        begin
            hit_seen <= hit_seen | hit;
            chan_seen <= {row, col};
        end
        sel_q <= o_sel;
        code_q <= o_lines.code;
        fr_q <= o_lines.force_reset;
    end

    // One command cycle with optional capture fault or stuck unit
    task automatic run_cmd(input logic [1:0] u, input logic [7:0] c, input logic [7:0] m,
                           input logic stuck, input int exp_fr);
        int n;
        @(posedge i_clk);
        hit_seen <= 4'h0;
        chan_seen <= 7'h00;
        fr_count = 0;
        i_cmd_unit <= u;
        i_cmd_code <= c;
        i_cmd_valid <= 1'b1;
        flip <= m;
        preset <= stuck;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        flip <= 8'h00;
        #1;
        check(o_cmd_ready, 1'b0, "ready while busy");
        for (n = 0; n < 6000 && o_done !== 1'b1; n++)
        begin
            @(posedge i_clk);
            #1;
        end
        check(n < 6000, 1'b1, "no done");
        check(o_cmd_ready, 1'b1, "ready with done");
        check(fr_count, exp_fr, "forced reset count");
        check(o_result.fail, stuck, "fail flag");
        if (!stuck)
        begin
            check(o_result, {1'b0, m != 8'h00, m == 8'h00}, "result");
            check(hit_seen, 4'h1 << u, "unit hit");
            check(chan_seen, exp_chan(c), "channel");
            check(i_verify, 8'h00, "unit not reset");
        end
        else
            check(hit_seen, 4'h0, "hit on fail");
        @(posedge i_clk);
        preset <= 1'b0;
        #1;
        check(o_done, 1'b0, "done longer than one cycle");
        $display("test done: unit %0d code %h", u, c);
    endtask

    // Watchdog
    initial
    begin
        repeat (60000) @(posedge i_clk);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        check(i_verify, 8'h00, "power-up state");
        run_cmd(2'h1, 8'h55, 8'h00, 1'b0, 0);
        run_cmd(2'h2, 8'hAA, 8'h00, 1'b0, 0);
        run_cmd(2'h0, 8'h00, 8'h00, 1'b0, 0);
        run_cmd(2'h3, 8'hFF, 8'h00, 1'b0, 0);
        run_cmd(2'h3, 8'h3C, 8'h81, 1'b0, 1);
        run_cmd(2'h0, 8'h12, 8'h00, 1'b1, 3);
        run_cmd(2'h1, 8'hC3, 8'h00, 1'b0, 1);
        for (int k = 0; k < 6; k++)
        begin
            lfsr = lfsr_next(lfsr);
            run_cmd(lfsr[9:8], lfsr[7:0], k[0] ? (lfsr[23:16] | 8'h01) : 8'h00, 1'b0, k % 2);
        end
        report_and_stop();
    end
endmodule
